// ==== rtl/bsmu_pkg.sv ====
package bsmu_pkg;

   // ---------------------------------------------------------------
   // operations, states, widths
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_BCD_DIFFERENCE_32,
      OP_REAL_DIFFERENCE,
      OP_BCD_PRODUCT_16,
      OP_BCD_PRODUCT_32,
      OP_REAL_PRODUCT
   } bsmu_op_e;

   typedef enum logic {ST_IDLE, ST_CONV} bsmu_state_e;

   localparam int ACC_W     = 32;
   localparam int DIGITS    = 8;
   localparam int PROD_BIN  = 54;
   localparam int PROD_DIG  = 16;
   localparam int LOW_DIG   = 4;

   // ---------------------------------------------------------------
   // status flag positions and per-operation flag sets
   // ---------------------------------------------------------------
   localparam int FL_ZERO   = 0;
   localparam int FL_CLOW   = 1;
   localparam int FL_CFULL  = 2;
   localparam int FL_NEG    = 3;
   localparam int FL_BPTR   = 4;
   localparam int FL_INVF   = 5;
   localparam int FL_SIGN   = 6;
   localparam int FL_UFLOW  = 7;
   localparam int FL_BDIG   = 8;
   localparam int NFLAG     = 9;

   localparam logic [NFLAG-1:0] FM_BCD_SUB = 9'h10f;
   localparam logic [NFLAG-1:0] FM_BCD_MUL = 9'h109;
   localparam logic [NFLAG-1:0] FM_REAL    = 9'h1f9;
   localparam logic [NFLAG-1:0] FM_PTR     = 9'h010;
   localparam logic [NFLAG-1:0] FM_ERR     = 9'h1f0;

   // ---------------------------------------------------------------
   // register map, events, reset values
   // ---------------------------------------------------------------
   localparam logic [3:0] RA_FLAGS = 4'h0;
   localparam logic [3:0] RA_EVENT = 4'h4;
   localparam logic [3:0] RA_MASK  = 4'h8;
   localparam logic [3:0] RA_ACC   = 4'hc;

   localparam int EV_DONE = 0;
   localparam int EV_ERR  = 1;
   localparam int NEVT    = 2;

   localparam logic [ACC_W-1:0] ACC_RST  = 32'h0000_0000;
   localparam logic [NEVT-1:0]  MASK_RST = 2'h0;

   // ---------------------------------------------------------------
   // single precision fields
   // ---------------------------------------------------------------
   localparam logic [7:0]  FP_EMAX = 8'hff;
   localparam logic [9:0]  FP_BIAS = 10'h07f;
   localparam logic [31:0] FP_QNAN = 32'h7fc0_0000;

   // packed decimal to binary, lowest nibble is the units digit
   function automatic logic [63:0] bsmu_bcd2bin(input logic [63:0] v);
      logic [63:0] r;
      r = 64'h0;
      for (int i = PROD_DIG - 1; i >= 0; i--) begin
         r = r * 64'h000a + {60'h0, v[4*i +: 4]};
      end
      return r;
   endfunction

endpackage

// ==== rtl/bsmu_bin2bcd.sv ====
`timescale 1ns/1ps
module bsmu_bin2bcd
   import bsmu_pkg::*;
#(
   parameter int BIN_W  = PROD_BIN,
   parameter int NDIG   = PROD_DIG
) (
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic              start,
   input  wire logic [BIN_W-1:0]  bin,
   output logic                   done,
   output logic [4*NDIG-1:0]      bcd
);
   localparam int CW = $clog2(BIN_W + 1);

   if (4 * NDIG < BIN_W) begin : g_chk
      $error("bsmu_bin2bcd: too few digits for the binary width");
   end

   typedef struct packed {
      logic                busy;
      logic [CW-1:0]       cnt;
      logic [BIN_W-1:0]    sh;
      logic [4*NDIG-1:0]   dig;
      logic                done;
   } bsmu_cv_s;

   bsmu_cv_s q, d;
   logic [4*NDIG-1:0] adj;

   // ---------------------------------------------------------------
   // add three to every digit above four before each shift
   // ---------------------------------------------------------------
   for (genvar g = 0; g < NDIG; g++) begin : g_dig
      assign adj[4*g +: 4] = (q.dig[4*g +: 4] > 4'h4) ? q.dig[4*g +: 4] + 4'h3
                                                     : q.dig[4*g +: 4];
   end

   // one bit per cycle: slow, but one adder per digit only
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (start && !q.busy) begin
         d.busy = 1'b1;
         d.cnt  = '0;
         d.sh   = bin;
         d.dig  = '0;
      end else if (q.busy) begin
         d.dig = {adj[4*NDIG-2:0], q.sh[BIN_W-1]};
         d.sh  = {q.sh[BIN_W-2:0], 1'b0};
         d.cnt = q.cnt + 1'b1;
         if (q.cnt == CW'(BIN_W - 1)) begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done = q.done;
   assign bcd  = q.dig;

endmodule

// ==== rtl/bsmu_core.sv ====
// Behaviour
// - bcd double subtract: acc minus operand
// - zero flag follows result equal zero
// - negative flag follows negative accumulator
// - low carry: borrow out of low word
// - full carry: borrow out of accumulator
// - bad decimal digit raises digit error
// - flags hold until next driving operation
// - real subtract leaves real result
// - invalid pointer raises pointer error
// - invalid float result raises flag
// - signed overflow raises sign error
// - float underflow raises underflow flag
// - non-real operand raises non-real flag
// - 16-bit bcd multiply, eight digit product
// - double multiply, upper digits to stack
// - real multiply leaves product in accumulator
`timescale 1ns/1ps
module bsmu_core
   import bsmu_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic              op_valid,
   input  wire bsmu_op_e          op_code,
   input  wire logic [ACC_W-1:0]  operand,
   input  wire logic              via_pointer,
   input  wire logic              pointer_ok,
   input  wire logic              acc_load,
   input  wire logic [ACC_W-1:0]  acc_load_data,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic [31:0]            reg_rdata,
   output logic [ACC_W-1:0]       accumulator,
   output logic [NFLAG-1:0]       flags,
   output logic                   busy,
   output logic                   done,
   output logic                   stack_push,
   output logic [ACC_W-1:0]       stack_data,
   output logic                   irq
);
   typedef struct packed {
      bsmu_state_e        st;
      bsmu_op_e           op;
      logic [ACC_W-1:0]   acc;
      logic [NFLAG-1:0]   flg;
      logic [NEVT-1:0]    evt;
      logic [NEVT-1:0]    msk;
      logic [31:0]        rdat;
      logic               done;
      logic               push;
      logic               irq;
      logic               bsy;
      logic               cst;
      logic [ACC_W-1:0]   stk;
      logic [63:0]        prod;
   } bsmu_core_s;

   bsmu_core_s q, d;

   // ---------------------------------------------------------------
   // decimal digit checks and ripple subtract
   // ---------------------------------------------------------------
   logic [DIGITS-1:0]  acc_dv;
   logic [DIGITS-1:0]  opd_dv;
   logic [DIGITS:0]    brw;
   logic [ACC_W-1:0]   diff;
   logic [4:0]         dt [DIGITS];

   assign brw[0] = 1'b0;
   for (genvar g = 0; g < DIGITS; g++) begin : g_dig
      assign acc_dv[g]  = q.acc[4*g +: 4] <= 4'h9;
      assign opd_dv[g]  = operand[4*g +: 4] <= 4'h9;
      assign dt[g]      = {1'b0, q.acc[4*g +: 4]} - {1'b0, operand[4*g +: 4]}
                          - {4'h0, brw[g]};
      assign brw[g+1]   = dt[g][4];
      assign diff[4*g +: 4] = dt[g][4] ? dt[g][3:0] + 4'ha : dt[g][3:0];
   end

   // ---------------------------------------------------------------
   // single precision helpers; truncating, no denormals
   // ---------------------------------------------------------------
   function automatic logic fp_nonreal(input logic [31:0] x);
      return x[30:23] == FP_EMAX;
   endfunction

   function automatic logic [33:0] fp_add(input logic [31:0] a, input logic [31:0] b);
      logic [31:0] x, y, r;
      logic [26:0] mx, my;
      logic [27:0] s;
      logic [9:0]  e;
      logic [7:0]  sh;
      logic [4:0]  lz;
      logic        uf, ov;
      x = a;
      y = b;
      lz = '0;
      uf = 1'b0;
      ov = 1'b0;
      if (a[30:0] < b[30:0]) begin
         x = b;
         y = a;
      end
      mx = (x[30:23] == 8'h00) ? '0 : {1'b1, x[22:0], 3'h0};
      my = (y[30:23] == 8'h00) ? '0 : {1'b1, y[22:0], 3'h0};
      sh = x[30:23] - y[30:23];
      my = (sh > 8'h1a) ? '0 : my >> sh;
      s  = (x[31] == y[31]) ? {1'b0, mx} + {1'b0, my} : {1'b0, mx} - {1'b0, my};
      e  = {2'h0, x[30:23]};
      if (s[27]) begin
         s = s >> 1;
         e = e + 10'h001;
      end else begin
         for (int i = 0; i < 27; i++) begin
            if (s[i]) lz = 5'(26 - i);
         end
         s = s << lz;
         e = e - {5'h0, lz};
      end
      r = {x[31], e[7:0], s[25:3]};
      if (s == '0) begin
         r = '0;
      end else if (e[9] || e == 10'h000) begin
         r  = {x[31], 31'h0};
         uf = 1'b1;
      end else if (e >= {2'h0, FP_EMAX}) begin
         r  = {x[31], FP_EMAX, 23'h0};
         ov = 1'b1;
      end
      return {uf, ov, r};
   endfunction

   function automatic logic [33:0] fp_mul(input logic [31:0] a, input logic [31:0] b);
      logic [23:0] ma, mb;
      logic [47:0] p;
      logic [9:0]  e;
      logic [31:0] r;
      logic        sg, uf, ov;
      ma = (a[30:23] == 8'h00) ? '0 : {1'b1, a[22:0]};
      mb = (b[30:23] == 8'h00) ? '0 : {1'b1, b[22:0]};
      p  = ma * mb;
      e  = {2'h0, a[30:23]} + {2'h0, b[30:23]} - FP_BIAS;
      sg = a[31] ^ b[31];
      uf = 1'b0;
      ov = 1'b0;
      if (p[47]) begin
         r = {sg, 8'h00, p[46:24]};
         e = e + 10'h001;
      end else begin
         r = {sg, 8'h00, p[45:23]};
      end
      r[30:23] = e[7:0];
      if (ma == '0 || mb == '0) begin
         r = {sg, 31'h0};
      end else if (e[9] || e == 10'h000) begin
         r  = {sg, 31'h0};
         uf = 1'b1;
      end else if (e >= {2'h0, FP_EMAX}) begin
         r  = {sg, FP_EMAX, 23'h0};
         ov = 1'b1;
      end
      return {uf, ov, r};
   endfunction

   // ---------------------------------------------------------------
   // binary to decimal converter for products
   // ---------------------------------------------------------------
   logic                  cv_done;
   logic [4*PROD_DIG-1:0] cv_bcd;

   bsmu_bin2bcd #(.BIN_W(PROD_BIN), .NDIG(PROD_DIG)) u_conv (
      .clock (clock),
      .reset (reset),
      .start (q.cst),
      .bin   (q.prod[PROD_BIN-1:0]),
      .done  (cv_done),
      .bcd   (cv_bcd)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic              accept;
   logic [63:0]       bin_a, bin_b;
   logic [33:0]       fr;

   assign accept = op_valid && q.st == ST_IDLE;
   assign bin_a  = bsmu_bcd2bin({32'h0, q.acc});
   assign bin_b  = bsmu_bcd2bin({32'h0, operand});

   always_comb begin
      logic [NFLAG-1:0] nf;
      logic [NFLAG-1:0] fm;
      logic [NEVT-1:0]  ev;
      logic             upd, bad;
      nf  = q.flg;
      fm  = '0;
      ev  = '0;
      upd = 1'b0;
      bad = 1'b0;
      fr  = '0;
      d   = q;
      d.done = 1'b0;
      d.push = 1'b0;
      d.cst  = 1'b0;
      d.rdat = '0;
      if (acc_load && q.st == ST_IDLE && !op_valid) d.acc = acc_load_data;
      unique case (q.st)
         ST_IDLE: if (accept) begin
            d.op = op_code;
            upd  = 1'b1;
            if (via_pointer && !pointer_ok) begin
               fm = FM_PTR;
               nf[FL_BPTR] = 1'b1;
               d.done = 1'b1;
            end else begin
               nf[FL_BPTR] = 1'b0;
               unique case (op_code)
                  OP_BCD_DIFFERENCE_32: begin
                     fm  = FM_BCD_SUB | FM_PTR;
                     bad = !(&acc_dv && &opd_dv);
                     nf[FL_BDIG] = bad;
                     d.done = 1'b1;
                     if (!bad) begin
                        d.acc = diff;
                        nf[FL_ZERO]  = diff == '0;
                        nf[FL_CLOW]  = brw[LOW_DIG];
                        nf[FL_CFULL] = brw[DIGITS];
                        nf[FL_NEG]   = brw[DIGITS];
                     end
                  end
                  OP_BCD_PRODUCT_16, OP_BCD_PRODUCT_32: begin
                     fm  = FM_BCD_MUL | FM_PTR;
                     bad = (op_code == OP_BCD_PRODUCT_16)
                           ? !(&acc_dv[LOW_DIG-1:0] && &opd_dv[LOW_DIG-1:0])
                           : !(&acc_dv && &opd_dv);
                     nf[FL_BDIG] = bad;
                     if (bad) begin
                        d.done = 1'b1;
                     end else begin
                        if (op_code == OP_BCD_PRODUCT_16) begin
                           d.prod = bsmu_bcd2bin({48'h0, q.acc[15:0]})
                                  * bsmu_bcd2bin({48'h0, operand[15:0]});
                        end else begin
                           d.prod = bin_a * bin_b;
                        end
                        d.cst = 1'b1;
                        d.st  = ST_CONV;
                        upd   = 1'b0;
                     end
                  end
                  default: begin
                     fm = FM_REAL | FM_PTR;
                     nf[FL_BDIG] = fp_nonreal(q.acc) || fp_nonreal(operand);
                     if (op_code == OP_REAL_DIFFERENCE) begin
                        fr = fp_add(q.acc, {~operand[31], operand[30:0]});
                     end else begin
                        fr = fp_mul(q.acc, operand);
                     end
                     if (nf[FL_BDIG]) fr = {2'h0, FP_QNAN};
                     d.acc = fr[31:0];
                     nf[FL_ZERO]  = fr[30:0] == '0;
                     nf[FL_NEG]   = fr[31] && fr[30:0] != '0;
                     nf[FL_INVF]  = fp_nonreal(fr[31:0]);
                     nf[FL_SIGN]  = fr[32];
                     nf[FL_UFLOW] = fr[33];
                     d.done = 1'b1;
                  end
               endcase
            end
         end
         ST_CONV: if (cv_done) begin
            upd  = 1'b1;
            fm   = FM_BCD_MUL | FM_PTR;
            d.acc = cv_bcd[ACC_W-1:0];
            nf[FL_ZERO] = cv_bcd[ACC_W-1:0] == '0;
            nf[FL_NEG]  = 1'b0;
            nf[FL_BDIG] = 1'b0;
            nf[FL_BPTR] = 1'b0;
            if (q.op == OP_BCD_PRODUCT_32) begin
               d.push = 1'b1;
               d.stk  = cv_bcd[2*ACC_W-1:ACC_W];
            end
            d.st   = ST_IDLE;
            d.done = 1'b1;
         end
      endcase
      if (upd) d.flg = (q.flg & ~fm) | (nf & fm);
      ev[EV_DONE] = d.done;
      ev[EV_ERR]  = upd && |(d.flg & fm & FM_ERR);
      if (reg_write && reg_addr == RA_MASK) d.msk = reg_wdata[NEVT-1:0];
      if (reg_read) begin
         unique case (reg_addr)
            RA_FLAGS: d.rdat = {23'h0, q.flg};
            RA_EVENT: d.rdat = {30'h0, q.evt};
            RA_MASK:  d.rdat = {30'h0, q.msk};
            RA_ACC:   d.rdat = q.acc;
            default:  d.rdat = '0;
         endcase
      end
      // a new event beats the read-clear in the same cycle
      d.evt = ((reg_read && reg_addr == RA_EVENT) ? '0 : q.evt) | ev;
      d.irq = |(d.evt & d.msk);
      d.bsy = d.st != ST_IDLE;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         q      <= '0;
         q.st   <= ST_IDLE;
         q.acc  <= ACC_RST;
         q.msk  <= MASK_RST;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata   = q.rdat;
   assign accumulator = q.acc;
   assign flags       = q.flg;
   assign busy        = q.bsy;
   assign done        = q.done;
   assign stack_push  = q.push;
   assign stack_data  = q.stk;
   assign irq         = q.irq;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   logic ok_in;
   assign ok_in = accept && !(via_pointer && !pointer_ok);

   // real results count minus zero as zero, decimal ones do not
   logic last_real;
   assign last_real = q.op == OP_REAL_DIFFERENCE || q.op == OP_REAL_PRODUCT;

   a_zero_flag: assert property (
      done && !flags[FL_BPTR] && !flags[FL_BDIG] |-> flags[FL_ZERO]
      == (last_real ? accumulator[30:0] == '0 : accumulator == '0))
      else $error("zero flag disagrees with accumulator");
   a_bcd_diff: assert property (
      ok_in && op_code == OP_BCD_DIFFERENCE_32 && &acc_dv && &opd_dv && !brw[DIGITS]
      |=> done && bsmu_bcd2bin({32'h0, accumulator})
          == $past(bin_a) - $past(bin_b))
      else $error("decimal difference wrong");
   a_full_carry: assert property (
      ok_in && op_code == OP_BCD_DIFFERENCE_32 && &acc_dv && &opd_dv
      |=> flags[FL_CFULL] == ($past(bin_a) < $past(bin_b)) && flags[FL_NEG] == flags[FL_CFULL])
      else $error("full borrow flag wrong");
   a_low_carry: assert property (
      ok_in && op_code == OP_BCD_DIFFERENCE_32 && &acc_dv && &opd_dv
      |=> flags[FL_CLOW] == (bsmu_bcd2bin({48'h0, $past(q.acc[15:0])})
                             < bsmu_bcd2bin({48'h0, $past(operand[15:0])})))
      else $error("low borrow flag wrong");
   a_bad_digit: assert property (
      ok_in && op_code == OP_BCD_DIFFERENCE_32 && !(&acc_dv && &opd_dv)
      |=> flags[FL_BDIG] && $stable(accumulator) && done)
      else $error("bad digit not flagged");
   a_ptr_error: assert property (
      accept && via_pointer && !pointer_ok
      |=> flags[FL_BPTR] && $stable(accumulator) && $stable(flags[FL_ZERO]))
      else $error("pointer error not flagged");
   a_flag_hold: assert property (
      ok_in && op_code == OP_BCD_PRODUCT_32 |=> $stable(flags[FL_UFLOW]) && $stable(flags[FL_CLOW]))
      else $error("undriven flag changed");
   a_mul_time: assert property (
      ok_in && op_code == OP_BCD_PRODUCT_16 && &acc_dv[LOW_DIG-1:0] && &opd_dv[LOW_DIG-1:0]
      |-> ##[2:60] done)
      else $error("multiply did not finish");
   a_bcd_product_32_value: assert property (
      done && q.op == OP_BCD_PRODUCT_32 && !flags[FL_BDIG] && !flags[FL_BPTR]
      |-> stack_push && bsmu_bcd2bin({stack_data, accumulator}) == q.prod)
      else $error("double product wrong");
   a_nonreal: assert property (
      ok_in && op_code == OP_REAL_PRODUCT && fp_nonreal(operand)
      |=> flags[FL_BDIG] && flags[FL_INVF] && accumulator == FP_QNAN)
      else $error("non-real operand missed");
   a_rsub_self: assert property (
      ok_in && op_code == OP_REAL_DIFFERENCE && operand == q.acc && !fp_nonreal(operand)
      |=> accumulator == '0 && flags[FL_ZERO] && !flags[FL_NEG])
      else $error("real self difference not zero");
   a_underflow: assert property (
      done && last_real && flags[FL_UFLOW] && !flags[FL_BPTR] |-> accumulator[30:0] == '0)
      else $error("underflow result not zero");
   a_sign_err: assert property (
      done && flags[FL_SIGN] && !flags[FL_BPTR] |-> flags[FL_INVF])
      else $error("overflow without invalid float");

   c_bcd_difference_32: cover property (ok_in && op_code == OP_BCD_DIFFERENCE_32 ##1 flags[FL_CFULL]);
   c_push: cover property (stack_push);
   c_uflow: cover property (done && flags[FL_UFLOW]);
   c_irq: cover property ($rose(irq));

endmodule

// ==== tb/bsmu_seq_model.sv ====
`timescale 1ns/1ps
module bsmu_seq_model
   import bsmu_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              done,
   output bsmu_op_e               op_code,
   output logic                   op_valid,
   output logic [ACC_W-1:0]       operand,
   output logic                   via_pointer,
   output logic                   pointer_ok
);
   // ---------------------------------------------------------------
   // data memory and operation issue
   // ---------------------------------------------------------------
   logic [15:0] mem [0:15];

   initial begin
      foreach (mem[i]) mem[i] = 16'h0;
      op_code = OP_BCD_DIFFERENCE_32;
      op_valid = 1'b0;
      operand = 32'h0;
      via_pointer = 1'b0;
      pointer_ok = 1'b0;
   end

   // k is a constant, or a word address when p is set; low word first
   task automatic run(input bsmu_op_e op, input logic [31:0] k, input logic p);
      int n;
      n = 0;
      @(posedge clock);
      op_valid <= 1'b1;
      op_code <= op;
      via_pointer <= p;
      pointer_ok <= !p || (k < 32'hf);
      operand <= p ? {mem[k[3:0] + 4'h1], mem[k[3:0]]} : k;
      @(posedge clock);
      op_valid <= 1'b0;
      via_pointer <= 1'b0;
      pointer_ok <= 1'b0;
      // released bus shows garbage, not the last word
      operand <= ~operand;
      #1;
      // flags used only once done is seen
      while (done !== 1'b1 && n < 100) begin
         @(posedge clock);
         #1;
         n++;
      end
   endtask
endmodule

// ==== tb/bcd_real_sub_mul_unit_tb.sv ====
`timescale 1ns/1ps
module bcd_real_sub_mul_unit_tb
   import bsmu_pkg::*;
;
   logic              clock = 1'b0;
   logic              reset = 1'b1;
   logic              acc_load = 1'b0;
   logic [ACC_W-1:0]  acc_load_data = 32'h0;
   logic [3:0]        reg_addr = 4'h0;
   logic [31:0]       reg_wdata = 32'h0;
   logic              reg_write = 1'b0;
   logic              reg_read = 1'b0;
   logic [31:0]       reg_rdata, rd;
   logic [ACC_W-1:0]  accumulator, stack_data, operand;
   logic [NFLAG-1:0]  flags;
   logic              busy, done, stack_push, irq, op_valid, via_pointer, pointer_ok;
   bsmu_op_e          op_code;
   int                failures = 0;
   int                n_compared = 0;
   int                tno = 0;

   always #12.5 clock = ~clock;

   bsmu_seq_model seq (.clock(clock), .done(done), .op_code(op_code), .op_valid(op_valid),
      .operand(operand), .via_pointer(via_pointer), .pointer_ok(pointer_ok));

   bsmu_core dut (.clock(clock), .reset(reset), .op_valid(op_valid), .op_code(op_code),
      .operand(operand), .via_pointer(via_pointer), .pointer_ok(pointer_ok),
      .acc_load(acc_load), .acc_load_data(acc_load_data), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .accumulator(accumulator), .flags(flags), .busy(busy),
      .done(done), .stack_push(stack_push), .stack_data(stack_data), .irq(irq));

   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         failures++;
         $display("Error %0t: got %h exp %h", $time, s, e);
      end
   endtask

   task automatic final_report;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      rd = reg_rdata;
   endtask

   task automatic load(input logic [31:0] v);
      @(posedge clock);
      acc_load <= 1'b1;
      acc_load_data <= v;
      @(posedge clock);
      acc_load <= 1'b0;
   endtask

   // a hang in the model loop shows here as done still low
   task automatic t(input bsmu_op_e op, input logic [31:0] k, input logic p,
                    input logic [31:0] ea, input logic [8:0] ef, input logic [8:0] fm);
      seq.run(op, k, p);
      if (done !== 1'b1) begin
         failures++;
         final_report;
      end
      check(accumulator, ea);
      check(flags & fm, ef);
      check(busy, 32'h0);
      tno++;
      $display("test %0d done", tno);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      seq.mem[2] = 16'h1000;
      seq.mem[4] = 16'h0011;
      check(accumulator, 32'h0);
      check(flags, 32'h0);
      rd_reg(RA_MASK);
      check(rd, 32'h0);
      rd_reg(4'h2);
      check(rd, 32'h0);
      wr_reg(RA_MASK, 32'h3);
      load(32'h00001234);
      t(OP_BCD_DIFFERENCE_32, 32'h234, 1'b0, 32'h1000, 9'h000, 9'h1ff);
      check(irq, 32'h1);
      rd_reg(RA_EVENT);
      check(rd, 32'h1);
      @(posedge clock);
      #1;
      check(irq, 32'h0);
      t(OP_BCD_DIFFERENCE_32, 32'h2, 1'b1, 32'h0, 9'h001, 9'h1ff);
      t(OP_BCD_DIFFERENCE_32, 32'h1, 1'b0, 32'h99999999, 9'h00e, 9'h1ff);
      t(OP_BCD_DIFFERENCE_32, 32'ha, 1'b0, 32'h99999999, 9'h10e, 9'h1ff);
      rd_reg(RA_EVENT);
      check(rd, 32'h3);
      t(OP_BCD_DIFFERENCE_32, 32'hf, 1'b1, 32'h99999999, 9'h11e, 9'h1ff);
      load(32'h00991234);
      t(OP_BCD_PRODUCT_16, 32'h2, 1'b0, 32'h2468, 9'h006, 9'h1ff);
      load(32'h99999999);
      t(OP_BCD_PRODUCT_32, 32'h4, 1'b1, 32'h99999989, 9'h006, 9'h1ff);
      check(stack_push, 32'h1);
      check(stack_data, 32'h10);
      load(32'h3f800000);
      t(OP_REAL_DIFFERENCE, 32'h3f000000, 1'b0, 32'h3f000000, 9'h006, 9'h1ff);
      t(OP_REAL_PRODUCT, 32'h40400000, 1'b0, 32'h3fc00000, 9'h006, 9'h1ff);
      t(OP_REAL_DIFFERENCE, FP_QNAN, 1'b0, FP_QNAN, 9'h120, 9'h120);
      t(OP_REAL_PRODUCT, FP_QNAN, 1'b0, FP_QNAN, 9'h120, 9'h120);
      load(32'h00800000);
      t(OP_REAL_PRODUCT, 32'h3f000000, 1'b0, 32'h0, 9'h081, 9'h081);
      load(32'hbf800000);
      t(OP_REAL_PRODUCT, 32'h3f000000, 1'b0, 32'hbf000000, 9'h008, 9'h009);
      t(OP_REAL_DIFFERENCE, 32'hbf000000, 1'b0, 32'h0, 9'h001, 9'h009);
      load(32'h7f7fffff);
      t(OP_REAL_PRODUCT, 32'h40000000, 1'b0, 32'h7f800000, 9'h060, 9'h060);
      rd_reg(RA_FLAGS);
      check(rd, 32'h0000_0066);
      rd_reg(RA_ACC);
      check(rd, 32'h7f80_0000);
      final_report;
   end
endmodule
